// ==== testbench/scp_host.sv ====
/* spi host model driving the serial pins of scp_port.
   assumes a free running clk_i; bits are paced at 800 ns per sclk period. */
`timescale 1ns/1ps
module scp_host (
   input wire clk_i,
   input wire sdio_o,
   input wire sdio_oe_o,
   input wire sep_i,
   output reg sclk_o,
   output reg cs_n_o,
   output wire sdio_line_o
);
   reg drv_q, bit_q, tog_q;
   reg [7:0] rq [0:7];
   // a released line toggles so a stale level can never pass as data
   assign sdio_line_o = sdio_oe_o ? sdio_o : (drv_q ? bit_q : tog_q);
   always @(posedge clk_i) tog_q <= ~tog_q;
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      drv_q = 1'b0;
      bit_q = 1'b0;
      tog_q = 1'b0;
   end
   // ************************************************************
   // framing tasks
   // ************************************************************
   task half;
      begin
         repeat (4) @(posedge clk_i);
         #1;
      end
   endtask
   // one frame; cut stops it mid-byte to abort
   task frame(input [15:0] ins, input lsb, input integer nb, input integer cut,
      input [63:0] wd);
      integer i, j;
      begin
         cs_n_o = 1'b0;
         drv_q = 1'b1;
         for (i = 0; i < 16 + 8 * nb && i != cut; i = i + 1) begin
            j = i - 16;
            if (i < 16) bit_q = lsb ? ins[i] : ins[15 - i];
            else if (ins[15]) drv_q = 1'b0;
            else bit_q = wd[8 * (j / 8) + (lsb ? j % 8 : 7 - j % 8)];
            half;
            sclk_o = 1'b1;
            half;
            // sampled just before the fall: zero hold is not needed
            if (i >= 16) rq[j / 8][lsb ? j % 8 : 7 - j % 8] = sdio_oe_o ? sdio_line_o : sep_i;
            sclk_o = 1'b0;
         end
         half;
         cs_n_o = 1'b1;
         drv_q = 1'b0;
         half;
      end
   endtask
endmodule

// ==== testbench/scp_port_bench.sv ====
/* top bench for scp_port: random and corner reads, writes, aborts.
   assumes scp_host and scp_port_monitor are compiled first. */
`timescale 1ns/1ps
module scp_port_bench;
   reg clk_i = 1'b0;
   reg rst_i = 1'b1;
   reg view_q = 1'b0;
   reg [31:0] r;
   reg [12:0] last_wa;
   reg [7:0] last_wd;
   wire sclk, cs_n, sdio, sd_o, sd_oe, sep, stb, cmt, lsb, uni;
   wire [12:0] rd_addr, wr_addr;
   wire [7:0] wr_data;
   integer miscompares = 0, check_count = 0, seed = 45381, ncommit = 0, n, b;
   // ************************************************************
   // clock, instances, register stand-in
   // ************************************************************
   always #50 clk_i = ~clk_i;
   scp_host i_scp_host (.clk_i(clk_i), .sdio_o(sd_o), .sdio_oe_o(sd_oe), .sep_i(sep),
      .sclk_o(sclk), .cs_n_o(cs_n), .sdio_line_o(sdio));
   scp_port i_scp_port (.clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk), .cs_n_i(cs_n),
      .sdio_i(sdio), .sdio_o(sd_o), .sdio_oe_o(sd_oe), .separate_readback_pin_o(sep),
      .view_active_i(view_q), .buf_rdata_i(rd_addr[11:4] ^ 8'h5a),
      .act_rdata_i(rd_addr[7:0] ^ 8'hc3), .rd_addr_o(rd_addr), .wr_addr_o(wr_addr),
      .wr_data_o(wr_data), .wr_stb_o(stb), .commit_o(cmt), .lsb_first_o(lsb),
      .unidir_o(uni));
   // capture what the port hands to the register array
   always @(posedge clk_i) begin
      if (stb) begin
         last_wa <= wr_addr;
         last_wd <= wr_data;
      end
      if (cmt) ncommit <= ncommit + 1;
   end
   function [7:0] exp_of(input [12:0] ad, input v);
      exp_of = (ad > 13'h0234) ? 8'h00 : (v ? ad[7:0] ^ 8'hc3 : ad[11:4] ^ 8'h5a);
   endfunction
   task check(input [31:0] seen, input [31:0] exp);
      begin
         check_count = check_count + 1;
         if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask
   task rd(input [12:0] ad, input [1:0] bc, input integer nb, input l);
      integer k;
      begin
         i_scp_host.frame({1'b1, bc, ad}, l, nb, -1, 64'h0);
         for (k = 0; k < nb; k = k + 1)
            check(i_scp_host.rq[k], exp_of(l ? ad + k[12:0] : ad - k[12:0], view_q));
      end
   endtask
   task wr(input [12:0] ad, input [7:0] d, input l);
      begin
         last_wa = 13'h1fff;
         i_scp_host.frame({1'b0, 2'h0, ad}, l, 1, -1, {56'h0, d});
         check(last_wa, ad);
         check(last_wd, d);
      end
   endtask
   task rnd(input l);
      for (n = 0; n < 6; n = n + 1) begin
         r = $random(seed);
         view_q = r[9];
         b = n % 3;
         rd(13'h010 + {4'h0, r[8:0]}, b[1:0], b + 1, l);
      end
   endtask
   task end_of_test;
      begin
         $display("checks %0d mismatches %0d", check_count, miscompares);
         if (miscompares == 0 && check_count > 0) $display("Finished cleanly");
         else $display("Finished with errors");
         $finish;
      end
   endtask
   // ************************************************************
   // main sequence and watchdog
   // ************************************************************
   initial begin
      repeat (20) @(posedge clk_i);
      #1 rst_i = 1'b0;
      repeat (5) @(posedge clk_i);
      rnd(1'b0);
      rd(13'h0002, 2'h3, 5, 1'b0);
      rd(13'h0001, 2'h2, 3, 1'b0);
      $display("msb reads done");
      i_scp_host.frame(16'h8010, 1'b0, 1, 5, 64'h0);
      rd(13'h0020, 2'h0, 1, 1'b0);
      wr(13'h00e0, 8'h3c, 1'b0);
      wr(13'h0234, 8'h01, 1'b0);
      check(ncommit, 1);
      wr(13'h0000, 8'h81, 1'b0);
      check(uni, 1'b1);
      rd(13'h0100, 2'h1, 2, 1'b0);
      $display("writes and unidirectional done");
      wr(13'h0000, 8'h42, 1'b0);
      check({uni, lsb}, 2'h1);
      rnd(1'b1);
      rd(13'h0233, 2'h2, 3, 1'b1);
      rd(13'h0232, 2'h3, 4, 1'b1);
      wr(13'h0000, 8'h00, 1'b1);
      check(lsb, 1'b0);
      $display("lsb reads done");
      end_of_test;
   end
   initial begin
      #6000000;
      miscompares = miscompares + 1;
      end_of_test;
   end
endmodule
bind scp_port scp_port_monitor i_scp_port_monitor (.clk_i(clk_i), .rst_i(rst_i),
   .sclk_i(sclk_i), .cs_n_i(cs_n_i), .sdio_o(sdio_o), .sdio_oe_o(sdio_oe_o),
   .separate_readback_pin_o(separate_readback_pin_o), .wr_addr_o(wr_addr_o),
   .wr_stb_o(wr_stb_o), .commit_o(commit_o), .lsb_first_o(lsb_first_o),
   .unidir_o(unidir_o));

// ==== testbench/scp_port_monitor.sv ====
/* checker for scp_port: pin-level timing and strobe properties.
   assumes it is bound to scp_port and clocked by the 10 MHz clk_i. */
`timescale 1ns/1ps
module scp_port_monitor (
   input wire clk_i,
   input wire rst_i,
   input wire sclk_i,
   input wire cs_n_i,
   input wire sdio_o,
   input wire sdio_oe_o,
   input wire separate_readback_pin_o,
   input wire [12:0] wr_addr_o,
   input wire wr_stb_o,
   input wire commit_o,
   input wire lsb_first_o,
   input wire unidir_o
);
   // ************************************************************
   // properties
   // ************************************************************
   // six idle cycles leave room for the chip select synchroniser
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   oe_idle_a: assert property (cs_n_i [*6] |-> !sdio_oe_o)
      else $error("shared pin driven while deselected");
   oe_unidir_a: assert property (unidir_o |-> !sdio_oe_o)
      else $error("shared pin driven in unidirectional mode");
   sep_quiet_a: assert property (!unidir_o [*3] |-> !separate_readback_pin_o)
      else $error("separate pin active in bidirectional mode");
   stb_pulse_a: assert property (wr_stb_o |=> !wr_stb_o)
      else $error("write strobe longer than one cycle");
   commit_pulse_a: assert property (commit_o |=> !commit_o)
      else $error("commit not self clearing");
   stb_range_a: assert property (wr_stb_o |-> wr_addr_o <= 13'h0234)
      else $error("write beyond last location");
   order_hold_a: assert property (cs_n_i [*6] |-> $stable(lsb_first_o))
      else $error("bit order changed outside a frame");
   stb_idle_a: assert property (cs_n_i [*6] |-> !wr_stb_o)
      else $error("write strobe while deselected");
   read_edge_a: assert property (sdio_oe_o && $past(sdio_oe_o) && $changed(sdio_o)
      |-> !$past(sclk_i, 2))
      else $error("read bit changed away from a falling edge");
endmodule

// ==== verilog/scp_map.vh ====
/*
 * constants for the serial control port read and addressing block:
 * instruction field positions, byte-count codes, address range, mode bits.
 * assumes inclusion by the single design file scp_port.v.
 */
`ifndef SCP_MAP_VH
`define SCP_MAP_VH

// ************************************************************
// instruction word layout
// ************************************************************
`define SCP_INSTR_BITS 16
`define SCP_INSTR_RW 15
`define SCP_BCC_HI 14
`define SCP_BCC_LO 13
`define SCP_ADDR_TOP 12
`define SCP_ADDR_W 13
`define SCP_CNT_W 5

// ************************************************************
// byte-count codes
// ************************************************************
`define SCP_BCC_ONE 2'h0
`define SCP_BCC_TWO 2'h1
`define SCP_BCC_THREE 2'h2
`define SCP_BCC_STREAM 2'h3

// ************************************************************
// address range and port configuration register
// ************************************************************
`define SCP_ADDR_LAST 13'h0234
`define SCP_ADDR_FIRST 13'h0000
`define SCP_CFG_ADDR 13'h0000
`define SCP_CFG_LSB_A 1
`define SCP_CFG_LSB_B 6
`define SCP_CFG_UNIDIR_A 0
`define SCP_CFG_UNIDIR_B 7
`define SCP_COMMIT_ADDR 13'h0234
`define SCP_COMMIT_BIT 0

// ************************************************************
// bit counts
// ************************************************************
`define SCP_LAST_BIT 3'h7
`define SCP_INSTR_LAST 5'h0f

`endif

// ==== verilog/scp_port.v ====
/*
 * spi serial control port, device side: instruction decode, address
 * generation, bit order, readback on the shared or separate pin.
 * assumes the register array sits outside: reads arrive as a byte for
 * the addressed location from both the buffer and the active view, and
 * written bytes leave as one-cycle strobes. serial pins are asynchronous.
 */
// What this block does
// RULE1 - read shifts out one to three bytes
// RULE2 - code three streams until chip select rises
// RULE3 - read data changes on falling clock edges
// RULE4 - host tolerates zero hold on final bit
// RULE5 - shared pin by default, separate pin unidirectional
// RULE6 - readback from buffer or active view
// RULE7 - instruction: flag, count code, thirteen-bit address
// RULE8 - count code decode: one, two, three, stream
// RULE9 - host keeps top address bit zero
// RULE10 - msb-first mode decrements address per byte
// RULE11 - lsb-first mode increments address per byte
// RULE12 - bit order follows msb or lsb mode
// RULE13 - host writes mirrored bytes to location zero
// RULE14 - lsb-first selection acts immediately, no commit
// RULE15 - address counter never skips any location
// RULE16 - past range end: suppress writes, read zeros
// RULE17 - streaming ends when counter crosses range end
// RULE18 - capture starts only with chip select low
// RULE19 - instruction and write bits taken on rising edges
// RULE20 - chip select mid-byte aborts and resets port
// RULE21 - writes buffered until self-clearing commit bit
// RULE22 - drive shared pin only in read data phase; code keeps it driven until chip select rises
// RULE23 - chip select high returns to instruction wait
`timescale 1ns/1ps
`include "scp_map.vh"

module scp_port (
   input wire clk_i,
   input wire rst_i,
   input wire sclk_i,
   input wire cs_n_i,
   input wire sdio_i,
   output reg sdio_o,
   output reg sdio_oe_o,
   output reg separate_readback_pin_o,
   input wire view_active_i,
   input wire [7:0] buf_rdata_i,
   input wire [7:0] act_rdata_i,
   output reg [12:0] rd_addr_o,
   output reg [12:0] wr_addr_o,
   output reg [7:0] wr_data_o,
   output reg wr_stb_o,
   output reg commit_o,
   output reg lsb_first_o,
   output reg unidir_o
);

   // ************************************************************
   // pin synchronisers
   // ************************************************************
   reg sclk_m_q, sclk_s_q, sclk_p_q;
   reg cs_m_q, cs_s_q, cs_p_q;
   reg sd_m_q, sd_s_q;

   // two stages each; sclk and chip select add a third stage, used for edge detection
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sclk_m_q <= 1'b0;
         sclk_s_q <= 1'b0;
         sclk_p_q <= 1'b0;
         cs_m_q <= 1'b1;
         cs_s_q <= 1'b1;
         cs_p_q <= 1'b1;
         sd_m_q <= 1'b0;
         sd_s_q <= 1'b0;
      end else begin
         sclk_m_q <= sclk_i;
         sclk_s_q <= sclk_m_q;
         sclk_p_q <= sclk_s_q;
         cs_m_q <= cs_n_i;
         cs_s_q <= cs_m_q;
         cs_p_q <= cs_s_q;
         sd_m_q <= sdio_i;
         sd_s_q <= sd_m_q;
      end
   end

   wire sclk_rise = sclk_s_q & ~sclk_p_q;
   wire sclk_fall = ~sclk_s_q & sclk_p_q;
   wire cs_rise = cs_s_q & ~cs_p_q;
   wire sel = ~cs_s_q;

   // ************************************************************
   // helpers
   // ************************************************************
   // next location in the current direction, never skipping one [RULE15]
   function [12:0] step_addr;
      input [12:0] a;
      input lsb;
      begin
         if (lsb)
            step_addr = a + 13'h0001; // [RULE11]
         else
            step_addr = a - 13'h0001; // [RULE10]
      end
   endfunction

   // true when stepping from a leaves the register range
   function crosses;
      input [12:0] a;
      input lsb;
      begin
         if (lsb)
            crosses = (a >= `SCP_ADDR_LAST);
         else
            crosses = (a == `SCP_ADDR_FIRST);
      end
   endfunction

   // ************************************************************
   // serial state machine
   // ************************************************************
   localparam ST_INSTR = 2'h0;
   localparam ST_DATA = 2'h1;
   localparam ST_DONE = 2'h2;

   reg [1:0] st_q;
   reg [4:0] icnt_q;
   reg [2:0] bcnt_q;
   reg [15:0] ish_q;
   reg [7:0] dsh_q;
   reg rd_q;
   reg [1:0] bcc_q;
   reg [1:0] left_q;
   reg out_q;
   reg dead_q;
   reg [12:0] addr_q;

   // shift register value with the new bit placed by the bit order [RULE12]
   wire [15:0] ish_d = lsb_first_o ? {sd_s_q, ish_q[15:1]} : {ish_q[14:0], sd_s_q};
   wire [7:0] dsh_d = lsb_first_o ? {sd_s_q, dsh_q[7:1]} : {dsh_q[6:0], sd_s_q};
   // readback byte from the selected view, zero past the range [RULE6] [RULE16]
   wire [7:0] rbyte = dead_q ? 8'h00 : (view_active_i ? act_rdata_i : buf_rdata_i);
   wire last_bit = (bcnt_q == `SCP_LAST_BIT);

   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_q <= ST_INSTR;
         icnt_q <= 5'h00;
         bcnt_q <= 3'h0;
         ish_q <= 16'h0000;
         dsh_q <= 8'h00;
         rd_q <= 1'b0;
         bcc_q <= 2'h0;
         left_q <= 2'h0;
         dead_q <= 1'b0;
         addr_q <= 13'h0000;
         wr_stb_o <= 1'b0;
         wr_addr_o <= 13'h0000;
         wr_data_o <= 8'h00;
         commit_o <= 1'b0;
         lsb_first_o <= 1'b0;
         unidir_o <= 1'b0;
      end else begin
         wr_stb_o <= 1'b0;
         commit_o <= 1'b0;
         if (cs_rise && (st_q == ST_DONE || (st_q == ST_INSTR && icnt_q == 5'h00))) begin
            // clean end: wait for a fresh instruction [RULE23]
            st_q <= ST_INSTR;
            icnt_q <= 5'h00;
            bcnt_q <= 3'h0;
         end else if (cs_rise) begin
            // chip select rose anywhere else, mid-instruction or in the data phase, mid-byte or between stream bytes: abort [RULE20]
            st_q <= ST_INSTR;
            icnt_q <= 5'h00;
            bcnt_q <= 3'h0;
         end else if (sel && sclk_rise) begin
            // capture only with chip select low, on rising edges [RULE18] [RULE19]
            case (st_q)
               ST_INSTR: begin
                  ish_q <= ish_d;
                  icnt_q <= icnt_q + 5'h01;
                  if (icnt_q == `SCP_INSTR_LAST) begin
                     // decode flag, count code and address [RULE7] [RULE8]
                     st_q <= ST_DATA;
                     bcnt_q <= 3'h0;
                     rd_q <= ish_d[`SCP_INSTR_RW];
                     bcc_q <= ish_d[`SCP_BCC_HI:`SCP_BCC_LO];
                     left_q <= ish_d[`SCP_BCC_HI:`SCP_BCC_LO];
                     addr_q <= ish_d[`SCP_ADDR_TOP:0];
                     dead_q <= 1'b0;
                  end
               end
               ST_DATA: begin
                  dsh_q <= dsh_d;
                  bcnt_q <= bcnt_q + 3'h1;
                  if (last_bit) begin
                     // byte done: write it if still in range, then step [RULE16]
                     if (!rd_q && !dead_q) begin
                        wr_stb_o <= 1'b1;
                        wr_addr_o <= addr_q;
                        wr_data_o <= dsh_d;
                        // port settings act at once, no commit needed [RULE14]
                        if (addr_q == `SCP_CFG_ADDR) begin
                           lsb_first_o <= dsh_d[`SCP_CFG_LSB_A] | dsh_d[`SCP_CFG_LSB_B];
                           unidir_o <= dsh_d[`SCP_CFG_UNIDIR_A] | dsh_d[`SCP_CFG_UNIDIR_B];
                        end
                        // self-clearing commit pulse [RULE21]
                        if (addr_q == `SCP_COMMIT_ADDR)
                           commit_o <= dsh_d[`SCP_COMMIT_BIT];
                     end
                     if (crosses(addr_q, lsb_first_o))
                        dead_q <= 1'b1;
                     addr_q <= step_addr(addr_q, lsb_first_o);
                     if (bcc_q == `SCP_BCC_STREAM) begin
                        // streaming stops once the range end is crossed [RULE2] [RULE17]
                        if (crosses(addr_q, lsb_first_o))
                           st_q <= ST_DONE;
                     end else if (left_q == 2'h0) begin
                        st_q <= ST_DONE; // fixed count reached [RULE1]
                     end else begin
                        left_q <= left_q - 2'h1;
                     end
                  end
               end
               ST_DONE: begin
                  st_q <= ST_DONE;
               end
               default: begin
                  st_q <= ST_INSTR;
               end
            endcase
         end
      end
   end

   // ************************************************************
   // read output path
   // ************************************************************
   // bits change on falling edges; a new byte loads at bit zero [RULE3]
   // the host's zero-hold tolerance on the last bit is not relied on [RULE4]
   wire rd_phase = sel && (st_q == ST_DATA) && rd_q;
   // the pin stays driven after the last bit until chip select rises, so the
   // final bit keeps its level past the last rising edge [RULE4]
   wire rd_hold = sel && rd_q && ((st_q == ST_DATA) || (st_q == ST_DONE));
   wire bit_sel = lsb_first_o ? rbyte[bcnt_q] : rbyte[3'h7 - bcnt_q];
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         out_q <= 1'b0;
      end else begin
         // after a stream has crossed the range end only zeros follow [RULE17]
         if (rd_hold && sclk_fall)
            out_q <= rd_phase ? bit_sel : 1'b0;
      end
   end

   // pins and read address; outputs all registered
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sdio_o <= 1'b0;
         sdio_oe_o <= 1'b0;
         separate_readback_pin_o <= 1'b0;
         rd_addr_o <= 13'h0000;
      end else begin
         rd_addr_o <= addr_q;
         // shared pin driven from the read data phase until chip select rises, never when unidirectional [RULE22] [RULE5]
         sdio_oe_o <= rd_hold && !unidir_o;
         sdio_o <= out_q;
         // separate pin carries read data only in unidirectional mode, held low otherwise [RULE5]
         separate_readback_pin_o <= unidir_o ? out_q : 1'b0;
      end
   end

endmodule
